// ===== verilog/pio_pkg.sv
/*
  pio_pkg: constants, register map and carrier types of the parallel
  port block. Assumes a 32-bit classic Wishbone register bus.
*/
package pio_pkg;

  ////////////////////////////////////////////////////////////////////
  // geometry
  localparam int PIO_PORTS = 3;
  localparam int PIO_W     = 16;

  ////////////////////////////////////////////////////////////////////
  // address decode: byte address = port*0x20 + reg*4, control at 0x60
  localparam int         PIO_ADR_REG_LSB  = 2;
  localparam int         PIO_ADR_PORT_LSB = 5;
  localparam int         PIO_ADR_TOP_BIT  = 7;
  localparam logic [1:0] PIO_CTRL_PORT    = 2'h3;
  localparam logic [2:0] PIO_OFS_DIR      = 3'h0;
  localparam logic [2:0] PIO_OFS_LAT      = 3'h1;
  localparam logic [2:0] PIO_OFS_LVL      = 3'h2;
  localparam logic [2:0] PIO_OFS_ODC      = 3'h3;
  localparam logic [2:0] PIO_OFS_ANS      = 3'h4;
  localparam logic [2:0] PIO_OFS_CTRL     = 3'h0;

  // control register fields
  localparam int PIO_CTRL_HOLD_BIT  = 0;
  localparam int PIO_CTRL_SLEEP_BIT = 1;

  ////////////////////////////////////////////////////////////////////
  // reset values and implemented-bit masks
  localparam logic [PIO_W-1:0] PIO_DIR_RST  = 16'hffff;
  localparam logic [PIO_W-1:0] PIO_LAT_RST  = 16'h0000;
  localparam logic [PIO_W-1:0] PIO_ODC_RST  = 16'h0000;
  localparam logic [PIO_W-1:0] PIO_ANS_RST  = 16'hffff;
  localparam logic [PIO_W-1:0] PIO_MASK_ALL = 16'hffff;
  // analog-capable pins: port c 2..0, port b 15..12 and 4..0, port a 3..0
  localparam logic [PIO_PORTS-1:0][PIO_W-1:0] PIO_ANS_MASK =
    {16'h0007, 16'hf01f, 16'h000f};

  ////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [PIO_W-1:0] dir;
    logic [PIO_W-1:0] lat;
    logic [PIO_W-1:0] odc;
    logic [PIO_W-1:0] ans;
  } pio_cfg_t;

  typedef enum logic [1:0] {
    PIO_RUN   = 2'h0,
    PIO_SLEEP = 2'h1,
    PIO_WAKE  = 2'h3
  } pio_hold_t;

endpackage

// ===== verilog/pio_pin_mux.sv
/*
  pio_pin_mux: per-pin output ownership, open-drain shaping, input
  synchroniser and input buffer gating for one 16-pin port.
  Assumes pin and peripheral inputs synchronous to clk_i except pin_in_i,
  which is synchronised here.
*/
`timescale 1ns/100ps
module pio_pin_mux
  import pio_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             hold_i,
  input  wire pio_cfg_t         cfg_i,
  input  wire logic [PIO_W-1:0] impl_i,
  input  wire logic [PIO_W-1:0] periph_en_i,
  input  wire logic [PIO_W-1:0] periph_oe_i,
  input  wire logic [PIO_W-1:0] periph_out_i,
  input  wire logic [PIO_W-1:0] pin_in_i,
  output logic      [PIO_W-1:0] pin_out_o,
  output logic      [PIO_W-1:0] pin_oe_o,
  output logic      [PIO_W-1:0] periph_in_o,
  output logic      [PIO_W-1:0] conv_ext_o,
  output logic      [PIO_W-1:0] lvl_o
);

  ////////////////////////////////////////////////////////////////////
  genvar b;
  generate
    for (b = 0; b < PIO_W; b++)
    begin : g_pin
      logic sync1_r;
      logic sync2_r;
      logic own;
      logic dig;
      logic oe_nxt;
      logic out_nxt;

      // two-stage synchroniser on the pin level
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
        end
        else if (ce_i)
        begin
          sync1_r <= pin_in_i[b];
          sync2_r <= sync1_r;
        end
      end

      // an enabled peripheral that drives owns the pin
      assign own     = periph_en_i[b] & periph_oe_i[b];
      // analog select switches the digital buffer off
      assign dig     = sync2_r & ~cfg_i.ans[b];
      // open drain releases instead of driving high
      assign oe_nxt  = impl_i[b] & (own | (~cfg_i.dir[b] &
                       ~(cfg_i.odc[b] & cfg_i.lat[b])));
      assign out_nxt = own ? periph_out_i[b] :
                       (cfg_i.lat[b] & ~cfg_i.odc[b]);
      assign lvl_o[b] = dig & impl_i[b];

      // pad drive, frozen while pins are held
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          pin_oe_o[b]  <= 1'b0;
          pin_out_o[b] <= 1'b0;
        end
        else if (ce_i && !hold_i)
        begin
          pin_oe_o[b]  <= oe_nxt;
          pin_out_o[b] <= out_nxt;
        end
      end

      // peripheral input and converter source
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          periph_in_o[b] <= 1'b0;
          conv_ext_o[b]  <= 1'b0;
        end
        else if (ce_i)
        begin
          periph_in_o[b] <= (~own & ~cfg_i.dir[b]) ? 1'b0 : dig;
          conv_ext_o[b]  <= cfg_i.ans[b] & cfg_i.dir[b];
        end
      end
    end
  endgenerate

endmodule

// ===== verilog/pio_top.sv
/*
  pio_top: three parallel i/o ports with direction, latch, pin level,
  open-drain and analog select registers behind a classic Wishbone slave,
  plus pin hold across deep sleep.
  Assumes one clock, synchronous active-high reset, clock enable ce_i,
  and a master that keeps each request until ack.
*/
`timescale 1ns/100ps
module pio_top
  import pio_pkg::*;
#(
  parameter logic [PIO_PORTS-1:0][PIO_W-1:0] PIN_MASK = {PIO_PORTS{PIO_MASK_ALL}}
)
(
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            ce_i,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [7:0]                      wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  input  wire logic                            deep_sleep_i,
  input  wire logic [PIO_PORTS-1:0][PIO_W-1:0] pin_in_i,
  input  wire logic [PIO_PORTS-1:0][PIO_W-1:0] periph_en_i,
  input  wire logic [PIO_PORTS-1:0][PIO_W-1:0] periph_oe_i,
  input  wire logic [PIO_PORTS-1:0][PIO_W-1:0] periph_out_i,
  output logic      [PIO_PORTS-1:0][PIO_W-1:0] pin_out_o,
  output logic      [PIO_PORTS-1:0][PIO_W-1:0] pin_oe_o,
  output logic      [PIO_PORTS-1:0][PIO_W-1:0] periph_in_o,
  output logic      [PIO_PORTS-1:0][PIO_W-1:0] conv_ext_o,
  output logic                                 hold_o
);

  ////////////////////////////////////////////////////////////////////
  // storage
  logic      [PIO_PORTS-1:0][PIO_W-1:0] dir_r;
  logic      [PIO_PORTS-1:0][PIO_W-1:0] lat_r;
  logic      [PIO_PORTS-1:0][PIO_W-1:0] odc_r;
  logic      [PIO_PORTS-1:0][PIO_W-1:0] ans_r;
  logic      [PIO_PORTS-1:0][PIO_W-1:0] lvl_w;
  logic      [PIO_PORTS-1:0][PIO_W-1:0] own_w;
  logic      [PIO_PORTS-1:0][PIO_W-1:0] ans_impl;
  pio_hold_t                            hold_r;
  pio_hold_t                            hold_nxt;
  logic                                 ack_r;
  logic      [31:0]                     rdat_r;
  logic      [31:0]                     rdat_nxt;

  // decode
  logic             req_w;
  logic             wr_w;
  logic [1:0]       port_sel_w;
  logic [2:0]       reg_sel_w;
  logic             hit_port_w;
  logic             hit_ctrl_w;
  logic [PIO_W-1:0] wmask_w;
  logic [PIO_W-1:0] lat_sel_w;
  logic [PIO_W-1:0] ans_sel_w;

  ////////////////////////////////////////////////////////////////////
  // merge a byte-laned write into a 16-bit register
  function automatic logic [PIO_W-1:0] merge(input logic [PIO_W-1:0] old_v,
                                             input logic [PIO_W-1:0] new_v,
                                             input logic [PIO_W-1:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // request decode; unmapped addresses still get an ack with zero data
  assign req_w      = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_w       = req_w & wb_we_i;
  assign port_sel_w = wb_adr_i[PIO_ADR_PORT_LSB +: 2];
  assign reg_sel_w  = wb_adr_i[PIO_ADR_REG_LSB +: 3];
  assign hit_port_w = ~wb_adr_i[PIO_ADR_TOP_BIT] & (port_sel_w != PIO_CTRL_PORT)
                      & (reg_sel_w <= PIO_OFS_ANS);
  assign hit_ctrl_w = ~wb_adr_i[PIO_ADR_TOP_BIT] & (port_sel_w == PIO_CTRL_PORT)
                      & (reg_sel_w == PIO_OFS_CTRL);
  assign wmask_w    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign own_w      = periph_en_i & periph_oe_i;
  assign lat_sel_w  = hit_port_w ? lat_r[port_sel_w] : '0;
  assign ans_sel_w  = hit_port_w ? ans_r[port_sel_w] : '0;

  // analog bits exist only where the pin has an analog function
  assign ans_impl   = PIN_MASK & PIO_ANS_MASK;

  ////////////////////////////////////////////////////////////////////
  // direction registers, all inputs after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dir_r <= PIN_MASK & {PIO_PORTS{PIO_DIR_RST}};
    else if (ce_i && wr_w && hit_port_w && reg_sel_w == PIO_OFS_DIR)
    begin
      for (int p = 0; p < PIO_PORTS; p++)
        if (port_sel_w == p[1:0])
          dir_r[p] <= merge(dir_r[p], wb_dat_i[PIO_W-1:0], wmask_w) & PIN_MASK[p];
    end
  end

  // output latch, written through latch or pin level address
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lat_r <= {PIO_PORTS{PIO_LAT_RST}};
    else if (ce_i && wr_w && hit_port_w &&
             (reg_sel_w == PIO_OFS_LAT || reg_sel_w == PIO_OFS_LVL))
    begin
      for (int p = 0; p < PIO_PORTS; p++)
        if (port_sel_w == p[1:0])
          lat_r[p] <= merge(lat_r[p], wb_dat_i[PIO_W-1:0], wmask_w) & PIN_MASK[p];
    end
  end

  // open-drain select
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      odc_r <= {PIO_PORTS{PIO_ODC_RST}};
    else if (ce_i && wr_w && hit_port_w && reg_sel_w == PIO_OFS_ODC)
    begin
      for (int p = 0; p < PIO_PORTS; p++)
        if (port_sel_w == p[1:0])
          odc_r[p] <= merge(odc_r[p], wb_dat_i[PIO_W-1:0], wmask_w) & PIN_MASK[p];
    end
  end

  // analog select, unimplemented bits held at zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ans_r <= ans_impl & {PIO_PORTS{PIO_ANS_RST}};
    else if (ce_i && wr_w && hit_port_w && reg_sel_w == PIO_OFS_ANS)
    begin
      for (int p = 0; p < PIO_PORTS; p++)
        if (port_sel_w == p[1:0])
          ans_r[p] <= merge(ans_r[p], wb_dat_i[PIO_W-1:0], wmask_w)
                      & ans_impl[p];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin hold: entered on deep sleep, left when software clears hold bit
  always_comb
  begin
    hold_nxt = hold_r;
    case (hold_r)
      PIO_RUN:
        if (deep_sleep_i)
          hold_nxt = PIO_SLEEP;
      PIO_SLEEP:
        if (!deep_sleep_i)
          hold_nxt = PIO_WAKE;
      PIO_WAKE:
        if (deep_sleep_i)
          hold_nxt = PIO_SLEEP;  // new sleep wins over the release
        else if (wr_w && hit_ctrl_w && wb_sel_i[0] &&
                 !wb_dat_i[PIO_CTRL_HOLD_BIT])
          hold_nxt = PIO_RUN;
      default:
        hold_nxt = PIO_RUN;
    endcase
  end

  // hold state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_r <= PIO_RUN;
    else if (ce_i)
      hold_r <= hold_nxt;
  end

  assign hold_o = hold_r[0];  // sleep and wake codes share bit 0

  ////////////////////////////////////////////////////////////////////
  // read data selection
  always_comb
  begin
    rdat_nxt = '0;
    if (hit_ctrl_w)
    begin
      rdat_nxt[PIO_CTRL_HOLD_BIT]  = hold_r[0];
      rdat_nxt[PIO_CTRL_SLEEP_BIT] = (hold_r == PIO_SLEEP);
    end
    else if (hit_port_w)
    begin
      case (reg_sel_w)
        PIO_OFS_DIR: rdat_nxt[PIO_W-1:0] = dir_r[port_sel_w];
        PIO_OFS_LAT: rdat_nxt[PIO_W-1:0] = lat_r[port_sel_w];
        PIO_OFS_LVL: rdat_nxt[PIO_W-1:0] = lvl_w[port_sel_w];
        PIO_OFS_ODC: rdat_nxt[PIO_W-1:0] = odc_r[port_sel_w];
        PIO_OFS_ANS: rdat_nxt[PIO_W-1:0] = ans_r[port_sel_w];
        default:     rdat_nxt = '0;
      endcase
    end
  end

  // bus answer: ack one cycle after the request, then dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else if (ce_i)
      ack_r <= req_w;
  end

  // read data register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_r <= '0;
    else if (ce_i && req_w)
      rdat_r <= wb_we_i ? 32'h0000_0000 : rdat_nxt;
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  ////////////////////////////////////////////////////////////////////
  // per-port pin logic
  genvar gp;
  generate
    for (gp = 0; gp < PIO_PORTS; gp++)
    begin : g_port
      pio_pin_mux u_mux (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .ce_i         (ce_i),
        .hold_i       (hold_o),
        .cfg_i        (pio_cfg_t'{dir: dir_r[gp], lat: lat_r[gp],
                                  odc: odc_r[gp], ans: ans_r[gp]}),
        .impl_i       (PIN_MASK[gp]),
        .periph_en_i  (periph_en_i[gp]),
        .periph_oe_i  (periph_oe_i[gp]),
        .periph_out_i (periph_out_i[gp]),
        .pin_in_i     (pin_in_i[gp]),
        .pin_out_o    (pin_out_o[gp]),
        .pin_oe_o     (pin_oe_o[gp]),
        .periph_in_o  (periph_in_o[gp]),
        .conv_ext_o   (conv_ext_o[gp]),
        .lvl_o        (lvl_w[gp])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence lat_rd_s;
    ce_i && req_w && !wb_we_i && hit_port_w && reg_sel_w == PIO_OFS_LAT;
  endsequence

  sequence lvl_rd_s;
    ce_i && req_w && !wb_we_i && hit_port_w && reg_sel_w == PIO_OFS_LVL;
  endsequence

  sequence lvl_wr_s;
    ce_i && wr_w && hit_port_w && port_sel_w == 2'h0 &&
    reg_sel_w == PIO_OFS_LVL && wb_sel_i[1:0] == 2'h3;
  endsequence

  dir_reset_a: assert property ($fell(rst_i) |-> dir_r == PIN_MASK)
    else $error("pins not all inputs after reset");

  periph_own_a: assert property (ce_i && !hold_o |=>
      ((pin_oe_o & $past(own_w)) == ($past(own_w) & PIN_MASK)) &&
      ((pin_out_o & $past(own_w)) == ($past(periph_out_i) & $past(own_w))))
    else $error("driving peripheral does not own its pin");

  idle_periph_a: assert property (ce_i && !hold_o |=>
      ((pin_oe_o ^ ~$past(dir_r)) & PIN_MASK & ~$past(odc_r)
       & $past(periph_en_i) & ~$past(periph_oe_i)) == '0)
    else $error("idle peripheral blocks port drive");

  input_dir_a: assert property (ce_i && !hold_o |=>
      (pin_oe_o & ~$past(own_w) & $past(dir_r)) == '0)
    else $error("input pin driven by port");

  lat_read_a: assert property (lat_rd_s |=>
      wb_ack_o && wb_dat_o[PIO_W-1:0] == $past(lat_sel_w))
    else $error("latch read wrong");

  lvl_write_a: assert property (lvl_wr_s |=>
      lat_r[0] == ($past(wb_dat_i[PIO_W-1:0]) & PIN_MASK[0]))
    else $error("pin level write missed latch");

  unimpl_zero_a: assert property (
      ((dir_r | lat_r | odc_r | pin_oe_o) & ~PIN_MASK) == '0)
    else $error("absent pin bit not zero");

  hold_freeze_a: assert property (hold_o |=>
      $stable(pin_oe_o) && $stable(pin_out_o))
    else $error("held pins changed");

  hold_keep_a: assert property (hold_r == PIO_WAKE && !(wr_w && hit_ctrl_w)
      |=> hold_o)
    else $error("hold dropped without release");

  open_drain_a: assert property (ce_i && !hold_o |=>
      (pin_oe_o & pin_out_o & ~$past(own_w) & $past(odc_r)) == '0)
    else $error("open drain pin driven high");

  analog_read_a: assert property (lvl_rd_s |=>
      (wb_dat_o[PIO_W-1:0] & $past(ans_sel_w)) == '0)
    else $error("analog pin read nonzero");

  loop_block_a: assert property (ce_i |=>
      (periph_in_o & ~$past(own_w) & ~$past(dir_r)) == '0)
    else $error("port output looped into peripheral");

  conv_src_a: assert property (ce_i |=>
      conv_ext_o == ($past(ans_r) & $past(dir_r)))
    else $error("converter source wrong");

  ans_bits_a: assert property ((ans_r & ~ans_impl) == '0)
    else $error("analog bit without analog pin");

  // ack follows a taken request; a low clock enable may stretch it
  bus_ack_a: assert property (ce_i && req_w |=> wb_ack_o)
    else $error("ack missing after request");

  ack_drop_a: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack not a single cycle");

  // nothing moves while the clock enable is low
  ce_freeze_a: assert property (!ce_i |=>
      $stable(pin_oe_o) && $stable(pin_out_o) && $stable(wb_ack_o) && $stable(hold_o))
    else $error("state moved with clock enable low");

endmodule

// ===== tb/pio_pad_model.sv
/*
  pio_pad_model: the pads and the board behind them.
  Assumes pad outputs from pio_top; board drive comes from the bench,
  and every pad has a pull-up.
*/
`timescale 1ns/100ps
module pio_pad_model
  import pio_pkg::*;
(
  input  wire logic [PIO_PORTS-1:0][PIO_W-1:0] pin_out_i,
  input  wire logic [PIO_PORTS-1:0][PIO_W-1:0] pin_oe_i,
  input  wire logic [PIO_PORTS-1:0][PIO_W-1:0] ext_en_i,
  input  wire logic [PIO_PORTS-1:0][PIO_W-1:0] ext_val_i,
  output logic      [PIO_PORTS-1:0][PIO_W-1:0] pad_o
);
  // driven pad shows the port, else the board, else the pull-up
  assign pad_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_val_i)
               | (~pin_oe_i & ~ext_en_i);
endmodule

// ===== tb/tb_top.sv
/*
  tb_top: self-checking bench of pio_top against a behavioural model.
  Assumes a 50 MHz clock, synchronous reset and the pad model.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb_top
  import pio_pkg::*;
;
  localparam logic [2:0][15:0] MSK = {16'h0fff, 16'hffff, 16'hffff};
  logic             clk_i, rst_i, ce_i, cyc, stb, we, deep_sleep, chk_in;
  logic [7:0]       adr;
  logic [31:0]      dat_w, dat_r;
  logic             ack, hold;
  logic [2:0][15:0] pen, poe, pout, ext_en, ext_val;
  logic [2:0][15:0] pad, pin_out, pin_oe, per_in, conv_ext;
  logic [15:0]      m_dir[3], m_lat[3], m_odc[3], m_ans[3];
  logic [15:0]      q, ho, hv;
  int               err_total, tests_run;

  ////////////////////////////////////////////////////////////////////
  // design, a narrowed port c models absent pins
  pio_top #(.PIN_MASK(MSK)) pio_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .deep_sleep_i(deep_sleep), .pin_in_i(pad),
    .periph_en_i(pen), .periph_oe_i(poe), .periph_out_i(pout), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe), .periph_in_o(per_in), .conv_ext_o(conv_ext), .hold_o(hold));
  pio_pad_model pio_pad_model_i (
    .pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pad_o(pad));

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////
  // model of pin ownership and pad levels
  function automatic logic [15:0] own(int p);
    return pen[p] & poe[p];
  endfunction
  function automatic logic [15:0] e_oe(int p);
    return MSK[p] & (own(p) | (~m_dir[p] & ~(m_odc[p] & m_lat[p])));
  endfunction
  function automatic logic [15:0] e_out(int p);
    return (own(p) & pout[p]) | (~own(p) & ~m_odc[p] & m_lat[p]);
  endfunction
  function automatic logic [15:0] e_pad(int p);
    logic [15:0] oe;
    oe = e_oe(p);
    return (oe & e_out(p)) | (~oe & ((ext_en[p] & ext_val[p]) | ~ext_en[p]));
  endfunction
  function automatic logic [15:0] e_reg(int p, int r);
    case (r)
      0: return m_dir[p];
      1: return m_lat[p];
      2: return e_pad(p) & ~m_ans[p] & MSK[p];
      3: return m_odc[p];
      default: return m_ans[p];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // model registers at their reset values, all pins inputs
  task automatic model_rst;
    for (int p = 0; p < 3; p++)
    begin
      m_dir[p] = MSK[p];
      m_lat[p] = 16'h0000;
      m_odc[p] = 16'h0000;
      m_ans[p] = PIO_ANS_MASK[p] & MSK[p];
    end
  endtask
  // classic single wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {16'h0000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      $display("ERROR %0t: no bus answer", $time);
    end
    q = dat_r[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // register write, mirrored into the model
  task automatic wr(input int p, input int r, input logic [15:0] d);
    logic [15:0] v;
    v = d & MSK[p];
    case (r)
      0: m_dir[p] = v;
      1, 2: m_lat[p] = v;
      3: m_odc[p] = v;
      default: m_ans[p] = v & PIO_ANS_MASK[p];
    endcase
    bus(1'b1, 8'(p * 32 + r * 4), d);
  endtask
  task automatic rd(input int p, input int r);
    bus(1'b0, 8'(p * 32 + r * 4), 16'h0000);
    `CHK(q, e_reg(p, r))
  endtask
  // let writes and the pin synchroniser settle, then compare every pin
  task automatic chk_pins;
    repeat (5) @(posedge clk_i);
    #1;
    for (int p = 0; p < 3; p++)
    begin
      `CHK(pin_oe[p], e_oe(p))
      `CHK(pin_out[p] & e_oe(p), e_out(p) & e_oe(p))
      `CHK(conv_ext[p], m_ans[p] & m_dir[p])
      if (chk_in)
        `CHK(per_in[p], e_pad(p) & ~m_ans[p] & ~(~own(p) & ~m_dir[p]) & MSK[p])
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  // verdict
  task summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #1000000;
    err_total++;
    summarize;
  end

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {cyc, stb, we, deep_sleep, adr, dat_w} = '0;
    {pen, poe, pout, ext_en, ext_val} = '0;
    err_total = 0;
    tests_run = 0;
    chk_in = 1'b1;
    ce_i = 1'b1;
    rst_i = 1'b1;
    void'($urandom(72980));
    model_rst;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values of every port register and pin
    chk_pins;
    for (int p = 0; p < 3; p++)
      for (int r = 0; r < 5; r++)
        rd(p, r);
    // analog selects all set, then all clear, random directions and data
    for (int k = 0; k < 2; k++)
      for (int p = 0; p < 3; p++)
      begin
        @(posedge clk_i);
        ext_en[p] <= 16'($urandom);
        ext_val[p] <= 16'($urandom);
        wr(p, 4, k ? 16'h0000 : 16'hffff);
        wr(p, 0, 16'($urandom));
        wr(p, 1, 16'($urandom));
        chk_pins;
        for (int r = 0; r < 5; r++)
          rd(p, r);
        wr(p, 2, 16'($urandom));
        rd(p, 1);
      end
    // open drain on port b
    chk_in = 1'b0;
    wr(1, 3, 16'hffff);
    wr(1, 0, 16'h0000);
    wr(1, 1, 16'ha5c3);
    chk_pins;
    rd(1, 2);
    wr(1, 3, 16'h0000);
    chk_in = 1'b1;
    // peripheral on port a: drives the low byte, input-only on the high
    @(posedge clk_i);
    pen[0] <= 16'hffff;
    poe[0] <= 16'h00ff;
    pout[0] <= 16'($urandom);
    wr(0, 0, 16'h0000);
    wr(0, 4, 16'h0000);
    chk_pins;
    rd(0, 2);
    // unmapped places answer zero
    bus(1'b0, 8'h1c, 16'h0000);
    `CHK(q, 16'h0000)
    bus(1'b0, 8'h64, 16'h0000);
    `CHK(q, 16'h0000)
    // deep sleep holds the pins until software releases them
    ho = e_oe(1);
    hv = e_out(1) & ho;
    @(posedge clk_i);
    deep_sleep <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(hold, 1'b1)
    wr(1, 1, ~m_lat[1]);
    wr(1, 0, 16'hffff);
    @(posedge clk_i);
    deep_sleep <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(hold, 1'b1)
    `CHK(pin_oe[1], ho)
    `CHK(pin_out[1] & ho, hv)
    bus(1'b0, 8'h60, 16'h0000);
    `CHK(q, 16'h0001)
    bus(1'b1, 8'h60, 16'h0000);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(hold, 1'b0)
    chk_pins;
    // clock enable low freezes the pad drive though the peripheral moves
    hv = pin_out[0];
    @(posedge clk_i);
    ce_i <= 1'b0;
    pout[0] <= ~pout[0];
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(pin_out[0], hv)
    @(posedge clk_i);
    ce_i <= 1'b1;
    chk_pins;
    // a second reset in mid-run, taken while the pins are held
    @(posedge clk_i);
    deep_sleep <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b1;
    deep_sleep <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    model_rst;
    chk_pins;
    `CHK(hold, 1'b0)
    for (int p = 0; p < 3; p++)
      for (int r = 0; r < 5; r++)
        rd(p, r);
    summarize;
  end
endmodule
